// >>> design/midi_uart_pkg.sv
package midi_uart_pkg;

  // Host port layout
  localparam logic [15:0] DATA_PORT_OFFSET   = 16'h0000;
  localparam logic [15:0] CMD_PORT_OFFSET    = 16'h0001;
  localparam logic [15:0] BASE_ADDR_RESET    = 16'h0000;
  localparam logic [3:0]  IRQ_LEVEL_RESET    = 4'h9;

  // Command codes and fixed bytes
  localparam logic [7:0]  CMD_RESET          = 8'hff;
  localparam logic [7:0]  CMD_UART_MODE      = 8'h3f;
  localparam logic [7:0]  ACK_BYTE           = 8'hfe;
  localparam logic [7:0]  EMPTY_READ_BYTE    = 8'h00;

  // Status port fields
  localparam int          STAT_RX_EMPTY_BIT  = 7;
  localparam int          STAT_TX_FULL_BIT   = 6;
  localparam logic [5:0]  STAT_RESERVED      = 6'h3f;

  // Special configuration register: receive trigger field
  localparam int          TRIG_FIELD_LSB     = 1;
  localparam int          TRIG_FIELD_MSB     = 2;
  localparam logic [4:0]  TRIG_LEVEL_0       = 5'h01;
  localparam logic [4:0]  TRIG_LEVEL_1       = 5'h04;
  localparam logic [4:0]  TRIG_LEVEL_2       = 5'h08;
  localparam logic [4:0]  TRIG_LEVEL_3       = 5'h0e;

  // Serial framing and timing
  localparam int          DATA_BITS          = 8;
  localparam int          FRAME_BITS         = 10;
  localparam int          CLOCK_PERIOD_NS    = 50;
  localparam int          BIT_TIME_NS        = 32000;
  localparam int          BIT_CYCLES         = BIT_TIME_NS / CLOCK_PERIOD_NS;
  localparam int          HALF_BIT_CYCLES    = BIT_CYCLES / 2;
  localparam int          FIFO_DEPTH         = 16;
  localparam int          SKID_DEPTH         = 2;

  typedef enum logic {MODE_INTELLIGENT, MODE_UART} mode_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } host_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } host_rsp_s;

endpackage

// >>> design/midi_byte_fifo.sv
`timescale 1ns/1ps
module midi_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_nrst,
  input  wire logic                       i_flush,
  input  wire logic                       i_valid,
  output      logic                       o_ready,
  input  wire logic [WIDTH-1:0]           i_data,
  output      logic                       o_valid,
  input  wire logic                       i_ready,
  output      logic [WIDTH-1:0]           o_data,
  output      logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire              push;
  wire              pop;

  // Depth is a power of two, so pointers wrap by overflow
  assign o_ready = (count != CW'(DEPTH));
  assign o_valid = (count != '0);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem[rd_ptr];
  assign o_count = count;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst || i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
      count  <= CW'(count + CW'(push) - CW'(pop));
    end
  end
endmodule

// >>> design/midi_uart_port.sv
`timescale 1ns/1ps
module midi_uart_port #(
  parameter int BIT_CYCLES_P = midi_uart_pkg::BIT_CYCLES
) (
  input  wire logic                      I_CLOCK,
  input  wire logic                      I_NRST,
  input  wire midi_uart_pkg::host_req_s  I_HOST_REQ,
  output      midi_uart_pkg::host_rsp_s  O_HOST_RSP,
  input  wire logic [15:0]               I_BASE_ADDR,
  input  wire logic [3:0]                I_IRQ_LEVEL,
  input  wire logic [7:0]                I_SPECIAL_CONFIG,
  input  wire logic                      I_SERIAL_IN_PIN,
  output      logic                      O_SERIAL_OUT_PIN,
  output      logic                      O_IRQ,
  output      logic [3:0]                O_IRQ_LEVEL,
  output      logic                      O_UART_MODE
);
  import midi_uart_pkg::*;

  localparam int BCW = $clog2(BIT_CYCLES_P + 1);
  localparam logic [BCW-1:0] BIT_LAST  = BCW'(BIT_CYCLES_P - 1);
  localparam logic [BCW-1:0] HALF_LAST = BCW'(BIT_CYCLES_P / 2 - 1);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  function automatic logic [4:0] trigger_level(input logic [1:0] sel);
    case (sel)
      2'h0:    trigger_level = TRIG_LEVEL_0;
      2'h1:    trigger_level = TRIG_LEVEL_1;
      2'h2:    trigger_level = TRIG_LEVEL_2;
      default: trigger_level = TRIG_LEVEL_3;
    endcase
  endfunction

  mode_e            mode;
  logic             ack_pending;
  host_rsp_s        rsp;
  logic             irq;
  logic [3:0]       irq_level;

  // Host decode
  wire              hit_data;
  wire              hit_cmd;
  wire              data_wr;
  wire              data_rd;
  wire              cmd_wr;
  wire              stat_rd;
  wire              uart_on;
  wire              cmd_reset;
  wire              cmd_uart;
  wire              ack_push;

  assign hit_data  = (I_HOST_REQ.addr == I_BASE_ADDR + DATA_PORT_OFFSET);
  assign hit_cmd   = (I_HOST_REQ.addr == I_BASE_ADDR + CMD_PORT_OFFSET);
  assign data_wr   = I_HOST_REQ.wr & hit_data;
  assign data_rd   = I_HOST_REQ.rd & hit_data;
  assign cmd_wr    = I_HOST_REQ.wr & hit_cmd;
  assign stat_rd   = I_HOST_REQ.rd & hit_cmd;
  assign uart_on   = (mode == MODE_UART);
  assign cmd_reset = cmd_wr & (I_HOST_REQ.wdata == CMD_RESET);
  assign cmd_uart  = cmd_wr & (I_HOST_REQ.wdata == CMD_UART_MODE) & !uart_on;
  assign ack_push  = cmd_uart;

  // Transmit FIFO
  wire              tx_fifo_ready;
  wire              tx_fifo_valid;
  wire [7:0]        tx_fifo_data;
  wire              tx_take;
  wire              tx_push;

  assign tx_push = data_wr & uart_on;

  midi_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clock (I_CLOCK),
    .i_nrst  (I_NRST),
    .i_flush (cmd_reset),
    .i_valid (tx_push),
    .o_ready (tx_fifo_ready),
    .i_data  (I_HOST_REQ.wdata),
    .o_valid (tx_fifo_valid),
    .i_ready (tx_take),
    .o_data  (tx_fifo_data),
    .o_count ()
  );

  // Receive path: deserialiser, two-entry buffer, receive FIFO
  wire              rx_byte_valid;
  wire              skid_ready;
  wire              skid_valid;
  wire [7:0]        skid_data;
  wire              skid_take;
  wire              rx_fifo_in_valid;
  wire [7:0]        rx_fifo_in_data;
  wire              rx_fifo_ready;
  wire              rx_fifo_valid;
  wire [7:0]        rx_fifo_data;
  wire [CW-1:0]     rx_count;
  wire              rx_pop;
  logic [7:0]       rx_shift;

  midi_byte_fifo #(
    .WIDTH (8),
    .DEPTH (SKID_DEPTH)
  ) u_rx_skid (
    .i_clock (I_CLOCK),
    .i_nrst  (I_NRST),
    .i_flush (cmd_reset),
    .i_valid (rx_byte_valid & uart_on),
    .o_ready (skid_ready),
    .i_data  (rx_shift),
    .o_valid (skid_valid),
    .i_ready (skid_take),
    .o_data  (skid_data),
    .o_count ()
  );

  // Acknowledge byte takes the FIFO input ahead of serial data
  assign skid_take        = rx_fifo_ready & !ack_push;
  assign rx_fifo_in_valid = ack_push | skid_valid;
  assign rx_fifo_in_data  = ack_push ? ACK_BYTE : skid_data;
  assign rx_pop           = data_rd & uart_on;

  midi_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clock (I_CLOCK),
    .i_nrst  (I_NRST),
    .i_flush (cmd_reset),
    .i_valid (rx_fifo_in_valid),
    .o_ready (rx_fifo_ready),
    .i_data  (rx_fifo_in_data),
    .o_valid (rx_fifo_valid),
    .i_ready (rx_pop),
    .o_data  (rx_fifo_data),
    .o_count (rx_count)
  );

  // Mode and acknowledge state
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST || cmd_reset) begin
      mode        <= MODE_INTELLIGENT;
      ack_pending <= 1'b0;
    end else if (cmd_uart) begin
      mode        <= MODE_UART;
      ack_pending <= 1'b1;
    end else if (rx_pop) begin
      ack_pending <= 1'b0;
    end
  end

  // Host read answers
  wire              rx_empty_flag;
  wire              tx_full_flag;
  wire [7:0]        status_byte;
  wire [7:0]        data_byte;
  wire [7:0]        next_rdata;

  assign rx_empty_flag = uart_on ? !rx_fifo_valid : 1'b0;
  assign tx_full_flag  = !tx_fifo_ready;
  assign status_byte   = {rx_empty_flag, tx_full_flag, STAT_RESERVED};
  assign data_byte     = !uart_on ? ACK_BYTE :
                         (rx_fifo_valid ? rx_fifo_data : EMPTY_READ_BYTE);
  assign next_rdata    = stat_rd ? status_byte : data_byte;

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      rsp <= '0;
    end else begin
      rsp.valid <= data_rd | stat_rd;
      rsp.data  <= (data_rd | stat_rd) ? next_rdata : rsp.data;
    end
  end

  // Receive interrupt follows fill level or pending acknowledge
  wire [4:0]        trig;
  wire              next_irq;

  assign trig     = trigger_level(I_SPECIAL_CONFIG[TRIG_FIELD_MSB:TRIG_FIELD_LSB]);
  assign next_irq = uart_on & ((5'(rx_count) >= trig) | ack_pending);

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      irq       <= 1'b0;
      irq_level <= IRQ_LEVEL_RESET;
    end else begin
      irq       <= next_irq;
      irq_level <= I_IRQ_LEVEL;
    end
  end

  // Transmitter
  tx_state_e        tx_state;
  logic [BCW-1:0]   tx_baud;
  logic [3:0]       tx_bits;
  logic [9:0]       tx_frame;
  logic             serial_out;
  wire              tx_bit_end;

  assign tx_bit_end = (tx_baud == BIT_LAST);
  assign tx_take    = (tx_state == TX_IDLE) & tx_fifo_valid & !cmd_reset;

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST || cmd_reset) begin
      tx_state   <= TX_IDLE;
      tx_baud    <= '0;
      tx_bits    <= '0;
      tx_frame   <= '1;
      serial_out <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          tx_baud    <= '0;
          tx_bits    <= '0;
          serial_out <= 1'b1;
          if (tx_take) begin
            tx_frame   <= {1'b1, tx_fifo_data, 1'b0};
            serial_out <= 1'b0;
            tx_state   <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          tx_baud <= tx_bit_end ? '0 : tx_baud + BCW'(1);
          if (tx_bit_end) begin
            tx_frame <= {1'b1, tx_frame[9:1]};
            tx_bits  <= tx_bits + 4'h1;
            if (tx_bits == 4'(FRAME_BITS - 1)) begin
              tx_state   <= TX_IDLE;
              serial_out <= 1'b1;
            end else begin
              serial_out <= tx_frame[1];
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Receiver with two-flop input synchroniser
  logic             in_meta;
  logic             in_sync;
  rx_state_e        rx_state;
  logic [BCW-1:0]   rx_baud;
  logic [3:0]       rx_bits;
  logic             rx_done;
  wire              rx_bit_end;
  wire              rx_half_end;

  assign rx_bit_end    = (rx_baud == BIT_LAST);
  assign rx_half_end   = (rx_baud == HALF_LAST);
  assign rx_byte_valid = rx_done;

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      in_meta <= 1'b1;
      in_sync <= 1'b1;
    end else begin
      in_meta <= I_SERIAL_IN_PIN;
      in_sync <= in_meta;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      rx_state <= RX_IDLE;
      rx_baud  <= '0;
      rx_bits  <= '0;
      rx_shift <= '0;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_baud <= '0;
          rx_bits <= '0;
          if (!in_sync) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          rx_baud <= rx_half_end ? '0 : rx_baud + BCW'(1);
          if (rx_half_end) begin
            rx_state <= in_sync ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          rx_baud <= rx_bit_end ? '0 : rx_baud + BCW'(1);
          if (rx_bit_end) begin
            rx_shift <= {in_sync, rx_shift[7:1]};
            rx_bits  <= rx_bits + 4'h1;
            if (rx_bits == 4'(DATA_BITS - 1)) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          rx_baud <= rx_bit_end ? '0 : rx_baud + BCW'(1);
          if (rx_bit_end) begin
            rx_done  <= in_sync;
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  assign O_HOST_RSP       = rsp;
  assign O_SERIAL_OUT_PIN = serial_out;
  assign O_IRQ            = irq;
  assign O_IRQ_LEVEL      = irq_level;
  assign O_UART_MODE      = (mode == MODE_UART);
endmodule

// >>> verif/midi_uart_monitor.sv
`timescale 1ns/1ps
module midi_uart_monitor
  import midi_uart_pkg::*;
#(
  parameter int BIT_CYCLES_P = BIT_CYCLES
) (
  input wire logic                     I_CLOCK,
  input wire logic                     I_NRST,
  input wire midi_uart_pkg::host_req_s I_HOST_REQ,
  input wire midi_uart_pkg::host_rsp_s O_HOST_RSP,
  input wire logic [15:0]              I_BASE_ADDR,
  input wire logic [3:0]               I_IRQ_LEVEL,
  input wire logic [7:0]               I_SPECIAL_CONFIG,
  input wire logic                     I_SERIAL_IN_PIN,
  input wire logic                     O_SERIAL_OUT_PIN,
  input wire logic                     O_IRQ,
  input wire logic [3:0]               O_IRQ_LEVEL,
  input wire logic                     O_UART_MODE
);
  wire hit_d = I_HOST_REQ.addr == I_BASE_ADDR;
  wire hit_c = I_HOST_REQ.addr == I_BASE_ADDR + 16'h0001;
  wire rd_any = I_HOST_REQ.rd && (hit_d || hit_c);
  wire wr_c = I_HOST_REQ.wr && hit_c;
  wire is_ff = wr_c && I_HOST_REQ.wdata == CMD_RESET;
  wire is_3f = wr_c && I_HOST_REQ.wdata == CMD_UART_MODE;

  default clocking @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_NRST);

  property p_read_answer;
    rd_any |-> ##1 O_HOST_RSP.valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray;
    O_HOST_RSP.valid |-> $past(rd_any);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without read");
  property p_status_rsvd;
    (I_HOST_REQ.rd && hit_c) |-> ##1 O_HOST_RSP.data[5:0] == STAT_RESERVED;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("reserved bits wrong");
  property p_intel_ack;
    (I_HOST_REQ.rd && hit_d && !O_UART_MODE) |-> ##1 O_HOST_RSP.data == ACK_BYTE;
  endproperty
  a_intel_ack: assert property (p_intel_ack) else $error("no acknowledge");
  property p_enter;
    is_3f |-> ##1 O_UART_MODE;
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");
  property p_leave;
    is_ff |-> ##1 !O_UART_MODE;
  endproperty
  a_leave: assert property (p_leave) else $error("mode not left");
  property p_ignore;
    !(is_ff || is_3f) |=> $stable(O_UART_MODE);
  endproperty
  a_ignore: assert property (p_ignore) else $error("mode changed alone");
  property p_irq_uart;
    O_IRQ |-> $past(O_UART_MODE);
  endproperty
  a_irq_uart: assert property (p_irq_uart) else $error("irq outside mode");
  property p_irq_level;
    $past(I_NRST) |-> O_IRQ_LEVEL == $past(I_IRQ_LEVEL);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
  property p_start_len;
    $fell(O_SERIAL_OUT_PIN) |-> !O_SERIAL_OUT_PIN [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("short low bit");

  c_enter: cover property (is_3f);
  c_irq: cover property ($rose(O_IRQ));
  c_tx: cover property ($fell(O_SERIAL_OUT_PIN));
endmodule

bind midi_uart_port midi_uart_monitor #(.BIT_CYCLES_P(BIT_CYCLES_P)) midi_uart_monitor_inst (
  .I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_HOST_REQ(I_HOST_REQ), .O_HOST_RSP(O_HOST_RSP),
  .I_BASE_ADDR(I_BASE_ADDR), .I_IRQ_LEVEL(I_IRQ_LEVEL), .I_SPECIAL_CONFIG(I_SPECIAL_CONFIG),
  .I_SERIAL_IN_PIN(I_SERIAL_IN_PIN), .O_SERIAL_OUT_PIN(O_SERIAL_OUT_PIN), .O_IRQ(O_IRQ),
  .O_IRQ_LEVEL(O_IRQ_LEVEL), .O_UART_MODE(O_UART_MODE)
);

// >>> verif/midi_peer.sv
`timescale 1ns/1ps
module midi_peer #(
  parameter int BITC = 16
) (
  input  wire logic i_clock,
  input  wire logic i_line,
  output      logic o_line
);
  logic [7:0] got[$];
  logic [7:0] sh;
  int         bad = 0;
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clock) o_line = fr[i];
      repeat (BITC - 1) @(negedge i_clock);
    end
  endtask
  // Receiver samples each bit at its middle
  initial forever begin
    @(negedge i_line);
    repeat (BITC / 2) @(posedge i_clock);
    if (i_line !== 1'b0) bad++;
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge i_clock);
      sh[i] = i_line;
    end
    repeat (BITC) @(posedge i_clock);
    if (i_line !== 1'b1) bad++;
    got.push_back(sh);
  end
endmodule

// >>> verif/test_midi_uart_interface.sv
`timescale 1ns/1ps
module test_midi_uart_interface;
  import midi_uart_pkg::*;
  localparam int BITC = 16;
  localparam int TRIG [4] = '{1, 4, 8, 14};
  logic        clock;
  logic        nrst;
  host_req_s   req;
  host_rsp_s   rsp;
  logic [15:0] base;
  logic [3:0]  irq_lvl;
  logic [3:0]  irq_lvl_o;
  logic [7:0]  cfg;
  logic        ser_in;
  logic        ser_out;
  logic        irq;
  logic        uart;
  logic [7:0]  q;
  logic [7:0]  exp_q[$];
  int          n_fail = 0;
  int          checked = 0;
  int          seed = 58;

  midi_uart_port #(.BIT_CYCLES_P(BITC)) midi_uart_port_inst (
    .I_CLOCK(clock), .I_NRST(nrst), .I_HOST_REQ(req), .O_HOST_RSP(rsp),
    .I_BASE_ADDR(base), .I_IRQ_LEVEL(irq_lvl), .I_SPECIAL_CONFIG(cfg),
    .I_SERIAL_IN_PIN(ser_in), .O_SERIAL_OUT_PIN(ser_out), .O_IRQ(irq),
    .O_IRQ_LEVEL(irq_lvl_o), .O_UART_MODE(uart)
  );
  midi_peer #(.BITC(BITC)) midi_peer_inst (.i_clock(clock), .i_line(ser_out), .o_line(ser_in));

  task automatic complete_run();
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic mapped(input logic [15:0] a);
    return a == base || a == base + 16'h0001;
  endfunction
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    req = {w, !w, a, d};
    @(negedge clock);
    req = '0;
    q = rsp.data;
    if (!w) chk({7'h0, rsp.valid}, {7'h0, mapped(a)});
  endtask
  task automatic wr(input logic [15:0] o, input logic [7:0] d);
    acc(1'b1, base + o, d);
  endtask
  task automatic rd(input logic [15:0] o, input logic [7:0] e);
    acc(1'b0, base + o, 8'h00);
    chk(q, e);
  endtask
  task automatic wait_irq(input logic v);
    int k;
    for (k = 0; k < 300 && irq !== v; k++) @(negedge clock);
    if (k == 300) begin
      chk({7'h0, irq}, {7'h0, v});
      complete_run();
    end
  endtask
  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 5000 && midi_peer_inst.got.size() < n; k++) @(negedge clock);
    chk(8'(midi_peer_inst.got.size()), 8'(n));
    if (k == 5000) complete_run();
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    base = BASE_ADDR_RESET;
    irq_lvl = 4'h9;
    cfg = 8'h00;
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    rd(1, 8'h3f);
    rd(0, ACK_BYTE);
    wr(0, 8'h5a);
    wr(1, 8'h12);
    acc(1'b0, base + 16'h0002, 8'h00);
    chk({7'h0, uart}, 8'h00);
    wr(1, CMD_UART_MODE);
    chk({7'h0, uart}, 8'h01);
    wait_irq(1'b1);
    wr(1, CMD_UART_MODE);
    wr(1, 8'h00);
    rd(0, ACK_BYTE);
    rd(1, 8'hbf);
    wait_irq(1'b0);
    // Each trigger code: just below, at, then just below the level again
    for (int t = 0; t < 4; t++) begin
      cfg = {5'h00, t[1:0], 1'b0};
      for (int i = 0; i < TRIG[t]; i++) begin
        if (i == TRIG[t] - 1) chk({7'h0, irq}, 8'h00);
        exp_q.push_back(8'($random(seed)));
        midi_peer_inst.send(exp_q[$]);
      end
      wait_irq(1'b1);
      rd(0, exp_q.pop_front());
      @(negedge clock);
      chk({7'h0, irq}, 8'h00);
      while (exp_q.size() > 0) rd(0, exp_q.pop_front());
    end
    cfg = 8'h00;
    for (int i = 0; i < FIFO_DEPTH + SKID_DEPTH + 1; i++) begin
      exp_q.push_back(8'($random(seed)));
      midi_peer_inst.send(exp_q[$]);
    end
    void'(exp_q.pop_back());
    while (exp_q.size() > 0) rd(0, exp_q.pop_front());
    rd(1, 8'hbf);
    for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
      exp_q.push_back(8'($random(seed)));
      wr(0, exp_q[$]);
    end
    rd(1, 8'hff);
    void'(exp_q.pop_back());
    wait_tx(FIFO_DEPTH + 1);
    repeat (400) @(negedge clock);
    for (int i = 0; i <= FIFO_DEPTH; i++) chk(midi_peer_inst.got[i], exp_q[i]);
    chk(8'(midi_peer_inst.got.size()), 8'(FIFO_DEPTH + 1));
    chk(8'(midi_peer_inst.bad), 8'h00);
    rd(1, 8'hbf);
    midi_peer_inst.send(8'h42);
    wr(1, CMD_RESET);
    chk({7'h0, uart}, 8'h00);
    rd(1, 8'h3f);
    wr(1, CMD_UART_MODE);
    rd(0, ACK_BYTE);
    rd(1, 8'hbf);
    base = 16'($random(seed)) & 16'hfffe;
    irq_lvl = 4'($random(seed));
    repeat (2) @(negedge clock);
    chk({4'h0, irq_lvl_o}, {4'h0, irq_lvl});
    rd(1, 8'hbf);
    complete_run();
  end
endmodule
